// ---- hw/mvs_consts.svh ----
`ifndef MVS_CONSTS_SVH
`define MVS_CONSTS_SVH
`define MVS_CODE_W      5
`define MVS_CODE_OFF    5'h1F
`define MVS_TOP_MV      12'h60E
`define MVS_STEP_MV     12'h019
`define MVS_SS_LAST     11'h7FF
`define MVS_SS_SPAN     19'h00800
`define MVS_SS_SHIFT    11
`define MVS_RAMP_NUM    26'h0000007
`define MVS_RAMP_DEN    26'h0000005
`define MVS_OFS_UA      19'h000A0
`define MVS_REG_CTRL    5'h00
`define MVS_REG_STATUS  5'h04
`define MVS_REG_LEVELS  5'h08
`define MVS_REG_SSCNT   5'h0C
`define MVS_REG_IRQ     5'h10
`define MVS_REG_MASK    5'h14
`define MVS_IRQ_W       4
`endif

// ---- hw/mvs_pkg.sv ----
package mvs_pkg;
	typedef enum logic [2:0] {
		mvs_st_off,
		mvs_st_shutdown,
		mvs_st_softstart,
		mvs_st_run,
		mvs_st_ov
	} mvs_state_type;
endpackage

// ---- hw/mvs_sequencer.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "mvs_consts.svh"

// Contract
// - Overvoltage above 2.1V drives every phase output low at once.
// - In overvoltage, release phases to high-Z at target; drive low on recurrence.
// - After overvoltage, switching stays off until the supply power-cycles.
// - Supply below power-on threshold keeps every phase output high-Z.
// - After power-on stay shut down until enable is above 1.23V.
// - Code 11111 enters shutdown; any other code starts up.
// - Supply good, enable high, code not 11111: start soft-start immediately; the code also holds shutdown while CTRL bit 0 is set.
// - Soft-start lasts 2048 phase-clock pulses on an 11-bit counter.
// - Ramp rises 0 to 140% of reference; offset current falls 160uA to 0.
// - During soft-start the target is the lower of reference and ramp.
// - Code inputs are checked only at each phase-1 cycle start; the code acts on 11111 at any clock and tracks pins each clock when inactive.
// - A code stable one more cycle moves reference 25mV every two cycles.
// - Codes decode to 25mV levels, 00000 highest, 11111 off.
module mvs_sequencer #(
	parameter int NUM_PHASES = 4                       // Phase outputs
) (
	input  wire logic                   clk,                       // 200 MHz clock
	input  wire logic                   resetn,                    // Async reset, low
	input  wire logic [4:0]             avs_address,               // Byte address
	input  wire logic                   avs_read,                  // Read request
	input  wire logic                   avs_write,                 // Write request
	input  wire logic [31:0]            avs_writedata,             // Write data
	input  wire logic [3:0]             avs_byteenable,            // Byte lanes
	output logic      [31:0]            avs_readdata,              // Read data
	output logic                        avs_waitrequest,           // Stall
	output logic                        irq,                       // Level interrupt
	input  wire logic                   por_ok_pin,                // Supply above POR
	input  wire logic                   enable_above_pin,          // Enable comparator
	input  wire logic                   ov_detect_pin,             // Output above 2.1V
	input  wire logic                   out_at_target_pin,         // Output at coded level
	input  wire logic                   phase_clk_pin,             // Phase clock
	input  wire logic                   phase1_start_pin,          // Phase-1 cycle start
	input  wire logic [4:0]             voltage_code_pin,          // Voltage code
	input  wire logic [NUM_PHASES-1:0]  pwm_cmd,                   // Modulator pulses
	output logic      [NUM_PHASES-1:0]  phase_out,                 // Phase level
	output logic      [NUM_PHASES-1:0]  phase_oe,                  // Phase drive enable
	output logic      [11:0]            coded_reference_level,     // Reference, mV
	output logic      [11:0]            soft_start_ramp,           // Ramp, mV
	output logic      [7:0]             soft_start_offset_current, // Offset, uA
	output logic      [11:0]            regulation_target,         // Effective target, mV
	output logic                        soft_start_active          // In soft-start
);
	localparam int SYNC_W = 6 + `MVS_CODE_W;

	logic [SYNC_W-1:0]      sync1_reg;
	logic [SYNC_W-1:0]      sync2_reg;
	logic [1:0]             edge_reg;
	mvs_pkg::mvs_state_type state_reg;
	mvs_pkg::mvs_state_type state_next;
	logic [10:0]            ss_cnt_reg;
	logic [10:0]            ss_cnt_next;
	logic [4:0]             ref_code_reg;
	logic [4:0]             target_reg;
	logic [4:0]             seen_reg;
	logic                   pending_reg;
	logic                   step_half_reg;
	logic                   ov_drive_reg;
	logic                   ctrl_reg;
	logic [3:0]             mask_reg;
	logic [3:0]             irq_stat_reg;
	logic [3:0]             irq_stat_next;
	logic                   ack_reg;
	logic [31:0]            readdata_reg;
	logic [31:0]            rd_mux;

	// Every pin is asynchronous to clk
	wire [SYNC_W-1:0] pins_raw = {voltage_code_pin, phase1_start_pin, phase_clk_pin,
		out_at_target_pin, ov_detect_pin, enable_above_pin, por_ok_pin};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			edge_reg <= '0;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			edge_reg <= sync2_reg[5:4];
		end
	end

	wire       por_ok      = sync2_reg[0];
	wire       en_ok       = sync2_reg[1];
	wire       ov_seen     = sync2_reg[2];
	wire       at_target   = sync2_reg[3];
	wire       phase_tick  = sync2_reg[4] & ~edge_reg[0];
	wire       cycle_start = sync2_reg[5] & ~edge_reg[1];
	wire [4:0] code_in     = sync2_reg[10:6];

	wire code_live = code_in != `MVS_CODE_OFF;
	wire go        = por_ok & en_ok & code_live & ~ctrl_reg;
	wire ss_now    = state_reg == mvs_pkg::mvs_st_softstart;
	wire active    = ss_now || state_reg == mvs_pkg::mvs_st_run;
	wire ss_end    = phase_tick && ss_cnt_reg == `MVS_SS_LAST;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			mvs_pkg::mvs_st_off: begin
				if (por_ok)
					state_next = mvs_pkg::mvs_st_shutdown;
			end
			mvs_pkg::mvs_st_shutdown: begin
				if (go)
					state_next = mvs_pkg::mvs_st_softstart;
			end
			mvs_pkg::mvs_st_softstart: begin
				if (!go)
					state_next = mvs_pkg::mvs_st_shutdown;
				else if (ss_end)
					state_next = mvs_pkg::mvs_st_run;
			end
			mvs_pkg::mvs_st_run: begin
				if (!go)
					state_next = mvs_pkg::mvs_st_shutdown;
			end
			default: begin
				state_next = mvs_pkg::mvs_st_ov;
			end
		endcase
		if (por_ok && ov_seen)
			state_next = mvs_pkg::mvs_st_ov;
		if (!por_ok)
			state_next = mvs_pkg::mvs_st_off;
	end

	// Entry and each recurrence drive low; reaching target releases
	wire in_ov_next    = state_next == mvs_pkg::mvs_st_ov;
	wire ov_drive_next = in_ov_next & (ov_seen | (state_reg != mvs_pkg::mvs_st_ov)
		| (ov_drive_reg & ~at_target));
	wire sw_next       = state_next == mvs_pkg::mvs_st_softstart
		|| state_next == mvs_pkg::mvs_st_run;

	// Counter is zero outside soft-start; a pulse on the entry cycle is not counted
	assign ss_cnt_next = (state_next != mvs_pkg::mvs_st_softstart || !ss_now) ? 11'h000
		: ss_cnt_reg + {10'h000, phase_tick};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= mvs_pkg::mvs_st_off;
			ss_cnt_reg <= '0;
			ov_drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ss_cnt_reg <= ss_cnt_next;
			ov_drive_reg <= ov_drive_next;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_PHASES; i++) begin : g_phase
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					phase_out[i] <= 1'b0;
					phase_oe[i] <= 1'b0;
				end else begin
					phase_out[i] <= sw_next & pwm_cmd[i];
					phase_oe[i] <= sw_next | ov_drive_next;
				end
			end
		end
	endgenerate

	// While active, code tracking runs on phase-1 cycle starts only; otherwise it follows the code pins every clock
	wire       code_changed = cycle_start & (code_in != seen_reg);
	wire       accept       = cycle_start & ~code_changed & pending_reg & code_live;
	wire       ref_moving   = ref_code_reg != target_reg;
	wire       step_due     = cycle_start & ref_moving & step_half_reg;
	wire [4:0] ref_step     = (target_reg < ref_code_reg) ? ref_code_reg - 5'h01
		: ref_code_reg + 5'h01;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_code_reg <= `MVS_CODE_OFF;
			target_reg <= `MVS_CODE_OFF;
			seen_reg <= `MVS_CODE_OFF;
			pending_reg <= 1'b0;
			step_half_reg <= 1'b0;
		end else if (!active) begin
			ref_code_reg <= code_in;
			target_reg <= code_in;
			seen_reg <= code_in;
			pending_reg <= 1'b0;
			step_half_reg <= 1'b0;
		end else if (cycle_start) begin
			seen_reg <= code_in;
			pending_reg <= code_changed;
			step_half_reg <= ref_moving & ~step_half_reg;
			if (accept)
				target_reg <= code_in;
			if (step_due)
				ref_code_reg <= ref_step;
		end
	end

	function automatic logic [11:0] mvs_level(input logic [4:0] c);
		mvs_level = (c == `MVS_CODE_OFF) ? 12'h000
			: `MVS_TOP_MV - `MVS_STEP_MV * {7'h00, c};
	endfunction

	// Ramp reaches 7/5 of the reference as the counter wraps
	wire [11:0] coded_lvl  = mvs_level(ref_code_reg);
	wire [25:0] ramp_prod  = {14'h0000, coded_lvl} * {15'h0000, ss_cnt_reg} * `MVS_RAMP_NUM;
	wire [25:0] ramp_wide  = (ramp_prod >> `MVS_SS_SHIFT) / `MVS_RAMP_DEN;
	wire [11:0] ramp_lvl   = ramp_wide[11:0];
	wire [18:0] ofs_prod   = `MVS_OFS_UA * (`MVS_SS_SPAN - {8'h00, ss_cnt_reg});
	wire [18:0] ofs_wide   = ofs_prod >> `MVS_SS_SHIFT;
	wire [11:0] ss_lvl     = (ramp_lvl < coded_lvl) ? ramp_lvl : coded_lvl;
	wire [11:0] target_lvl = ss_now ? ss_lvl : (active ? coded_lvl : 12'h000);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			coded_reference_level <= '0;
			soft_start_ramp <= '0;
			soft_start_offset_current <= '0;
			regulation_target <= '0;
			soft_start_active <= 1'b0;
		end else begin
			coded_reference_level <= active ? coded_lvl : 12'h000;
			soft_start_ramp <= ss_now ? ramp_lvl : 12'h000;
			soft_start_offset_current <= ss_now ? ofs_wide[7:0] : 8'h00;
			regulation_target <= target_lvl;
			soft_start_active <= ss_now;
		end
	end

	// One wait cycle per access; read data is captured in the wait cycle
	wire req     = avs_read | avs_write;
	wire first   = req & ~ack_reg;
	wire wr_fire = avs_write & ack_reg;
	wire rd_irq  = avs_read & ack_reg & (avs_address == `MVS_REG_IRQ);
	wire wr_ctrl = wr_fire & avs_byteenable[0] & (avs_address == `MVS_REG_CTRL);
	wire wr_mask = wr_fire & avs_byteenable[0] & (avs_address == `MVS_REG_MASK);

	assign avs_waitrequest = first;
	assign avs_readdata = readdata_reg;

	always_comb begin
		if (avs_address == `MVS_REG_CTRL)
			rd_mux = {31'h00000000, ctrl_reg};
		else if (avs_address == `MVS_REG_STATUS)
			rd_mux = {13'h0000, code_in, target_reg, ref_code_reg, ov_drive_reg, state_reg};
		else if (avs_address == `MVS_REG_LEVELS)
			rd_mux = {4'h0, coded_lvl, 4'h0, target_lvl};
		else if (avs_address == `MVS_REG_SSCNT)
			rd_mux = {21'h000000, ss_cnt_reg};
		else if (avs_address == `MVS_REG_IRQ)
			rd_mux = {28'h0000000, irq_stat_reg};
		else if (avs_address == `MVS_REG_MASK)
			rd_mux = {28'h0000000, mask_reg};
		else
			rd_mux = 32'h00000000;
	end

	wire ev_ov   = in_ov_next & (state_reg != mvs_pkg::mvs_st_ov);
	wire ev_ss   = ss_now & (state_next == mvs_pkg::mvs_st_run);
	wire ev_shut = active & (state_next == mvs_pkg::mvs_st_shutdown);
	wire [`MVS_IRQ_W-1:0] events = {ev_shut, accept, ev_ss, ev_ov};

	// Only bits seen by the read are cleared, so a new event survives
	assign irq_stat_next = (irq_stat_reg & ~(rd_irq ? readdata_reg[3:0] : 4'h0)) | events;
	assign irq = |(irq_stat_reg & mask_reg);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
			readdata_reg <= '0;
			ctrl_reg <= 1'b0;
			mask_reg <= '0;
			irq_stat_reg <= '0;
		end else begin
			ack_reg <= first;
			irq_stat_reg <= irq_stat_next;
			if (first && avs_read)
				readdata_reg <= rd_mux;
			if (wr_ctrl)
				ctrl_reg <= avs_writedata[0];
			if (wr_mask)
				mask_reg <= avs_writedata[3:0];
		end
	end

	a_ov_forces_low: assert property (@(posedge clk) disable iff (!resetn)
		(por_ok && ov_seen) |=> (&phase_oe) && !(|phase_out))
		else $error("phases not driven low on overvoltage");

	a_ov_release: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == mvs_pkg::mvs_st_ov && por_ok && !ov_seen && at_target)
		|=> (phase_oe == '0) && ov_drive_reg == 1'b0)
		else $error("phases not released at target");

	a_ov_latched: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == mvs_pkg::mvs_st_ov && por_ok) |=> state_reg == mvs_pkg::mvs_st_ov)
		else $error("overvoltage latch left without power cycle");

	a_por_hiz: assert property (@(posedge clk) disable iff (!resetn)
		!por_ok |=> (phase_oe == '0) && state_reg == mvs_pkg::mvs_st_off)
		else $error("phases driven below power-on threshold");

	a_enable_gate: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == mvs_pkg::mvs_st_shutdown && !en_ok)
		|=> state_reg != mvs_pkg::mvs_st_softstart)
		else $error("started with enable low");

	a_off_code: assert property (@(posedge clk) disable iff (!resetn)
		(active && !code_live) |=> !active)
		else $error("off code did not shut down");

	a_start_now: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == mvs_pkg::mvs_st_shutdown && go && !ov_seen)
		|=> state_reg == mvs_pkg::mvs_st_softstart ##0 ss_cnt_reg == 11'h000)
		else $error("soft-start not started at once");

	a_ss_count: assert property (@(posedge clk) disable iff (!resetn)
		(ss_now && state_next == mvs_pkg::mvs_st_softstart)
		|=> ss_cnt_reg == $past(ss_cnt_reg) + {10'h000, $past(phase_tick)})
		else $error("soft-start count not one per phase pulse");

	a_ss_finish: assert property (@(posedge clk) disable iff (!resetn)
		(ss_now && go && !ov_seen && ss_end) |=> state_reg == mvs_pkg::mvs_st_run)
		else $error("soft-start did not end after 2048 pulses");

	a_target_min: assert property (@(posedge clk) disable iff (!resetn)
		ss_now |-> target_lvl <= coded_lvl && target_lvl <= ramp_lvl)
		else $error("soft-start target not the lower value");

	a_ref_cadence: assert property (@(posedge clk) disable iff (!resetn)
		($past(active) && active && ref_code_reg != $past(ref_code_reg))
		|-> $past(cycle_start) && $past(step_half_reg)
		&& (ref_code_reg - $past(ref_code_reg) == 5'h01
		|| $past(ref_code_reg) - ref_code_reg == 5'h01))
		else $error("reference moved off cadence or by more than one step");

	a_shutdown_clear: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == mvs_pkg::mvs_st_shutdown |-> ss_cnt_reg == 11'h000 && phase_oe == '0)
		else $error("shutdown left count or drive active");
endmodule

// ---- dv/mvs_far_side.sv ----
`timescale 1ns/100ps
// Driver chips and processor code outputs; output voltage kept in mV
module mvs_far_side #(
	parameter int NUM_PHASES = 4 // Phase count
) (
	input  wire logic                  clk,       // Clock
	input  wire logic [NUM_PHASES-1:0] phase_out, // Phase level
	input  wire logic [NUM_PHASES-1:0] phase_oe,  // Phase drive enable
	output logic                       ph_clk,    // Phase clock
	output logic                       ph1_start, // Cycle start
	output logic      [4:0]            code,      // Voltage code
	output logic                       ov,        // Above 2.1V
	output logic                       at_tgt     // At coded level
);
	int vout_mv = 0;
	initial begin
		ph_clk = 1'b0;
		ph1_start = 1'b0;
		code = 5'h1F;
	end
	// Low switches on pull the output down; high-Z lets it hold
	always @(posedge clk)
		if ((phase_oe & ~phase_out) != '0 && vout_mv > 0)
			vout_mv <= vout_mv - 10;
	assign ov = vout_mv > 2100;
	assign at_tgt = vout_mv <= 1550 - 25 * int'(code);
	task automatic pulses(input bit first, input int n);
		repeat (n) begin
			@(posedge clk);
			ph1_start <= first;
			ph_clk <= !first;
			repeat (2) @(posedge clk);
			ph1_start <= 1'b0;
			ph_clk <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
endmodule

// ---- dv/multiphase_vr_sequencer_tb.sv ----
`timescale 1ns/100ps
`include "mvs_consts.svh"
module multiphase_vr_sequencer_tb;
	logic        clk;
	logic        resetn;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic        por_ok;
	logic        en_ok;
	logic [3:0]  pwm_cmd;
	logic [3:0]  phase_out;
	logic [3:0]  phase_oe;
	logic [11:0] ref_mv;
	logic [11:0] ramp_mv;
	logic [7:0]  ofs_ua;
	logic [11:0] tgt_mv;
	logic        ss_act;
	logic        ph_clk;
	logic        ph1;
	logic        ov;
	logic        at_tgt;
	logic [4:0]  code;
	logic [31:0] rd;
	int          mismatches = 0;
	int          n_tests = 0;
	int          c;
	int          exp_ref;
	int          p;
	int          ramp;
	int          i;

	mvs_sequencer #(.NUM_PHASES(4)) dut (.clk(clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.por_ok_pin(por_ok), .enable_above_pin(en_ok), .ov_detect_pin(ov),
		.out_at_target_pin(at_tgt), .phase_clk_pin(ph_clk), .phase1_start_pin(ph1),
		.voltage_code_pin(code), .pwm_cmd(pwm_cmd), .phase_out(phase_out),
		.phase_oe(phase_oe), .coded_reference_level(ref_mv), .soft_start_ramp(ramp_mv),
		.soft_start_offset_current(ofs_ua), .regulation_target(tgt_mv),
		.soft_start_active(ss_act));
	mvs_far_side #(.NUM_PHASES(4)) far (.clk(clk), .phase_out(phase_out),
		.phase_oe(phase_oe), .ph_clk(ph_clk), .ph1_start(ph1), .code(code),
		.ov(ov), .at_tgt(at_tgt));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
		pwm_cmd <= 4'($urandom);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Waitrequest and read data are taken at the rising edge, before its updates land
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		bit w;
		w = 1'b1;
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		for (int k = 0; k < 50 && w; k++) begin
			@(posedge clk);
			w = avs_waitrequest !== 1'b0;
			if (!w && !wr)
				rd = avs_readdata;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (w) begin
			mismatches++;
			end_sim();
		end
	endtask
	task automatic settle();
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic st(input int s);
		bus(1'b0, `MVS_REG_STATUS, 32'h0);
		check(rd[2:0], s);
	endtask
	task automatic dvid(input int nc);
		int tgt;
		tgt = 1550 - 25 * nc;
		@(posedge clk);
		far.code <= 5'h00;
		settle();
		@(posedge clk);
		far.code <= nc[4:0];
		for (int s = 0; s < 8; s++) begin
			far.pulses(1'b1, 1);
			settle();
			if (s >= 3 && s % 2 == 1 && exp_ref != tgt)
				exp_ref += (tgt > exp_ref) ? 25 : -25;
			check(ref_mv, exp_ref);
		end
	endtask
	task automatic ov_hit();
		@(posedge clk);
		far.vout_mv <= 2200;
		repeat (5) @(posedge clk);
		@(negedge clk);
		check(phase_oe, 4'hF);
		check(phase_out, 4'h0);
	endtask
	task automatic ov_release();
		for (i = 0; i < 1000 && phase_oe !== 4'h0; i++)
			@(negedge clk);
		check(phase_oe, 4'h0);
		check(far.vout_mv <= exp_ref, 1'b1);
		if (i == 1000)
			end_sim();
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		end_sim();
	end
	initial begin
		resetn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		por_ok = 1'b0;
		en_ok = 1'b0;
		pwm_cmd = 4'h0;
		void'($urandom(32'h7E87));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		settle();
		check(phase_oe, 4'h0);
		bus(1'b0, `MVS_REG_CTRL, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 5'h18, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, `MVS_REG_MASK, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, `MVS_REG_MASK, 32'hF);
		bus(1'b0, `MVS_REG_MASK, 32'h0);
		check(rd, 32'hF);
		st(0);
		por_ok <= 1'b1;
		settle();
		st(1);
		check(phase_oe, 4'h0);
		@(posedge clk);
		en_ok <= 1'b1;
		settle();
		st(1);
		c = $urandom_range(29, 2);
		exp_ref = 1550 - 25 * c;
		@(posedge clk);
		far.code <= c[4:0];
		settle();
		st(2);
		check(ss_act, 1'b1);
		check(ref_mv, exp_ref);
		p = $urandom_range(1900, 100);
		far.pulses(1'b0, p);
		settle();
		bus(1'b0, `MVS_REG_SSCNT, 32'h0);
		check(rd, p);
		ramp = exp_ref * 7 * p / 10240;
		check(ramp_mv, ramp);
		check(ofs_ua, 160 * (2048 - p) / 2048);
		check(tgt_mv, ramp < exp_ref ? ramp : exp_ref);
		far.pulses(1'b0, 2047 - p);
		settle();
		check(ss_act, 1'b1);
		far.pulses(1'b0, 1);
		settle();
		check(ss_act, 1'b0);
		st(3);
		bus(1'b0, `MVS_REG_LEVELS, 32'h0);
		check(rd, exp_ref * 65536 + exp_ref);
		bus(1'b0, `MVS_REG_IRQ, 32'h0);
		check(rd[1], 1'b1);
		settle();
		check(irq, 1'b0);
		dvid(c - 2);
		dvid(c + 1);
		bus(1'b0, `MVS_REG_IRQ, 32'h0);
		check(rd[2], 1'b1);
		bus(1'b1, `MVS_REG_CTRL, 32'h1);
		settle();
		st(1);
		check(phase_oe, 4'h0);
		bus(1'b0, `MVS_REG_SSCNT, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, `MVS_REG_IRQ, 32'h0);
		check(rd[3], 1'b1);
		bus(1'b1, `MVS_REG_CTRL, 32'h0);
		settle();
		check(ss_act, 1'b1);
		check(ref_mv, exp_ref);
		ov_hit();
		check(irq, 1'b1);
		bus(1'b0, `MVS_REG_IRQ, 32'h0);
		check(rd[0], 1'b1);
		ov_release();
		ov_hit();
		ov_release();
		@(posedge clk);
		en_ok <= 1'b0;
		settle();
		@(posedge clk);
		en_ok <= 1'b1;
		settle();
		st(4);
		check(phase_oe, 4'h0);
		@(posedge clk);
		por_ok <= 1'b0;
		settle();
		st(0);
		check(phase_oe, 4'h0);
		@(posedge clk);
		por_ok <= 1'b1;
		settle();
		st(2);
		end_sim();
	end
endmodule
